// ===== testbench/pstl_chan_model.sv
// Purpose: channel equipment model at the far side of the relay
// Assumes: remote transmitter state is commanded by the bench
// Notes:   receivers lag the remote key by one or four cycles
`timescale 1ns/1ns
module pstl_chan_model (
  // clock
  input  wire logic i_ref_clk,
  // remote transmitter keys and channel speed
  input  wire logic i_remote_key_one,
  input  wire logic i_remote_key_two,
  input  wire logic i_slow,
  // receiver outputs toward the relay
  output logic      o_rx_one,
  output logic      o_rx_two
);
  // =====================================================================
  // channel delay lines; a slow channel tests the timers' patience
  logic [3:0] dly_one_r = 4'h0;  // remote key one history
  logic [3:0] dly_two_r = 4'h0;  // remote key two history
  always_ff @(posedge i_ref_clk) begin
    dly_one_r <= {dly_one_r[2:0], i_remote_key_one};
    dly_two_r <= {dly_two_r[2:0], i_remote_key_two};
  end
  // receiver output follows the delayed key
  assign o_rx_one = i_slow ? dly_one_r[3] : dly_one_r[0];
  assign o_rx_two = i_slow ? dly_two_r[3] : dly_two_r[0];
endmodule : pstl_chan_model

// ===== testbench/pstl_trip_test.sv
// Purpose: self-checking bench for the pilot scheme trip logic
// Assumes: short tick of 4 cycles, short transient block timers
// Notes:   result bits are {trip, key, start, stop} under a mask
`timescale 1ns/1ns
module pstl_trip_test;
  import pstl_pkg::*;
  // =====================================================================
  // stimulus and observed signals
  localparam int TC = 4;         // cycles per tick, kept short
  logic       ref_clk = 1'b0;    // 25 MHz clock
  logic       rst     = 1'b1;    // sync reset
  pstl_mode_t scm     = PSTL_POTT;
  pstl_elem_t elem    = '0;      // element flags
  logic cnt_two = 1'b0, two_bkr = 1'b0, bkr_a = 1'b0, bkr_b = 1'b0;
  logic stop_in = 1'b0, dis_in = 1'b0, rk1 = 1'b0, rk2 = 1'b0;
  logic slow = 1'b0;             // channel speed for the model
  logic rx1, rx2, trip, key, cstart, cstop, tick;
  logic [7:0] notes_q[$];        // expected value and mask
  logic [3:0] tcnt;              // tick pulses seen
  int         n_errors = 0;
  int         check_count = 0;
  int         seed_v;
  event       smp;               // a result is ready to compare
  always #20 ref_clk = ~ref_clk;
  // =====================================================================
  // design and channel partner
  pstl_trip #(.TICK_CYC(TC), .GTB_PU(3), .GTB_DO(8), .DTB_PU(3),
    .DTB_DO(8)) dut (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_scheme_select(scm),
    .i_receiver_count_two(cnt_two), .i_two_breakers(two_bkr),
    .i_elem(elem), .i_breaker_open_input_a(bkr_a),
    .i_breaker_open_input_b(bkr_b), .i_receiver_input_one(rx1),
    .i_receiver_input_two(rx2), .i_transmitter_stop_input(stop_in),
    .i_pilot_disable_input(dis_in), .o_pilot_trip(trip),
    .o_tx_key(key), .o_carrier_start(cstart), .o_carrier_stop(cstop),
    .o_tick(tick));
  pstl_chan_model chan (.i_ref_clk(ref_clk), .i_remote_key_one(rk1),
    .i_remote_key_two(rk2), .i_slow(slow), .o_rx_one(rx1),
    .o_rx_two(rx2));
  // =====================================================================
  // tasks
  task automatic compare(input string nm, input logic [3:0] e,
                         input logic [3:0] s, input logic [3:0] m);
    check_count++;
    if (((s ^ e) & m) !== 4'h0) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e & m, s & m);
    end
  endtask : compare
  // inputs move 2 ns after the edge, never on it
  task automatic go(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : go
  task automatic expect_out(input int n, input logic [3:0] e,
                            input logic [3:0] m);
    go(n);
    notes_q.push_back({e, m});
    -> smp;
  endtask : expect_out
  // quiet inputs and a fresh reset so no timer carries over
  task automatic idle(input pstl_mode_t md);
    {elem, cnt_two, two_bkr, bkr_a, bkr_b} = '0;
    {stop_in, dis_in, rk1, rk2, slow} = '0;
    scm = md;
    rst = 1'b1;
    go(3);
    rst = 1'b0;
    go(1);
  endtask : idle
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // monitor: oldest note against the outputs
  always @(smp) begin
    compare("outputs", notes_q[0][7:4], {trip, key, cstart, cstop},
            notes_q[0][3:0]);
    void'(notes_q.pop_front());
  end
  // watchdog far beyond the expected run
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end
  // =====================================================================
  // scenarios
  initial begin
    seed_v = $urandom(32'hcac0);
    idle(PSTL_POTT);
    tcnt = 4'h0;
    for (int i = 0; i < 8 * TC; i++) begin
      go(1);
      tcnt = tcnt + {3'h0, tick};
    end
    compare("tick count", 4'h8, tcnt, 4'hf);
    // overreach with one receiver; unused breaker b is random
    bkr_b = 1'($urandom);
    {elem.overreach, elem.fault_det, rk1} = 3'h7;
    expect_out(1, 4'h4, 4'h4);
    expect_out(6, 4'h0, 4'h8);
    expect_out(48, 4'h8, 4'h8);
    elem.fault_det = 1'b0;
    expect_out(3, 4'h0, 4'h8);
    elem.fault_det = 1'b1;
    elem.oos_block = 1'b1;
    expect_out(12, 4'h0, 4'h8);
    idle(PSTL_POTT);
    cnt_two = 1'b1;
    {elem.overreach, elem.fault_det, rk1} = 3'h7;
    expect_out(48, 4'h0, 4'h8);
    rk2 = 1'b1;
    expect_out(48, 4'h8, 4'h8);
    // underreach: zone 1 direct, then either receiver
    idle(PSTL_PUTT);
    {elem.zone1, elem.fault_det} = 2'h3;
    expect_out(1, 4'hc, 4'hc);
    idle(PSTL_PUTT);
    {cnt_two, slow, rk2} = 3'h7;
    {elem.overreach, elem.fault_det} = 2'h3;
    expect_out(48, 4'h8, 4'h8);
    idle(PSTL_PUTT);
    {cnt_two, bkr_a} = 2'h3;
    expect_out(3, 4'h0, 4'h4);
    cnt_two = 1'b0;
    expect_out(3, 4'h4, 4'h4);
    idle(PSTL_POTT);
    {two_bkr, bkr_a} = 2'h3;
    expect_out(3, 4'h0, 4'h4);
    bkr_b = 1'b1;
    expect_out(3, 4'h4, 4'h4);
    stop_in = 1'b1; // external party closes the stop contact
    expect_out(3, 4'h0, 4'h4);
    // ground carrier start per blocking variant
    idle(PSTL_BLOCKING_VARIANT_ONE);
    elem.gnd_blk_oc = 1'b1;
    expect_out(3, 4'h0, 4'h2);
    elem.neg_seq_blk = 1'b1;
    expect_out(3, 4'h2, 4'h2);
    idle(PSTL_BLOCKING_VARIANT_TWO);
    elem.fault_det = 1'b1;
    expect_out(3, 4'h2, 4'h2);
    idle(PSTL_BLOCKING_VARIANT_THREE);
    elem.gnd_blk_unr = 1'b1;
    expect_out(3, 4'h2, 4'h2);
    // blocking trip after coordination, removed by receiver
    idle(PSTL_BLOCKING_VARIANT_ONE);
    {elem.overreach, elem.fault_det} = 2'h3;
    expect_out(3, 4'h1, 4'h1);
    expect_out(8, 4'h0, 4'h8);
    expect_out(48, 4'h8, 4'h8);
    rk1 = 1'b1;
    expect_out(12, 4'h0, 4'h8);
    idle(PSTL_BLOCKING_VARIANT_TWO);
    {elem.overreach, elem.fault_det, rk2, cnt_two} = 4'hf;
    expect_out(48, 4'h0, 4'h8);
    idle(PSTL_BLOCKING_VARIANT_ONE);
    elem.dist_block = 1'b1;
    expect_out(20, 4'h2, 4'h2);
    elem.dist_block = 1'b0;
    expect_out(8, 4'h2, 4'h2);
    {elem.overreach, elem.fault_det} = 2'h3;
    expect_out(30, 4'h8, 4'h8);
    // ground block held past pickup keeps its extended dropout
    idle(PSTL_BLOCKING_VARIANT_ONE);
    elem.ground_directional_overcurrent_block = 1'b1;
    go(20);
    elem.ground_directional_overcurrent_block = 1'b0;
    expect_out(8, 4'h2, 4'h2);
    {elem.overreach, elem.fault_det} = 2'h3;
    expect_out(22, 4'h0, 4'h8);
    expect_out(50, 4'h8, 4'h8);
    // pilot disable silences everything
    idle(PSTL_POTT);
    {elem.overreach, elem.fault_det, rk1, dis_in, bkr_a} = 5'h1f;
    expect_out(48, 4'h0, 4'hf);
    go(2);
    wrap_up();
  end
endmodule : pstl_trip_test

// ===== verilog/pstl_consts.svh
// Purpose: constants for the pilot scheme trip logic
// Assumes: 25 MHz clock, timers counted on a processing tick
// Notes:   times in microseconds, counts derived from the tick period
`ifndef PSTL_CONSTS_SVH
`define PSTL_CONSTS_SVH
// =====================================================================
// scheme select codes
`define PSTL_SCM_POTT      3'h1
`define PSTL_SCM_PUTT      3'h2
`define PSTL_SCM_BLK       3'h4
// =====================================================================
// timing: tick period and transient block figures
`define PSTL_TICK_US       1000
`define PSTL_TICK_CYC      (`PSTL_TICK_US * 25)
`define PSTL_GTB_PU_US     25000
`define PSTL_GTB_DO_US     30000
`define PSTL_GTB_PU_TICKS \
  ((`PSTL_GTB_PU_US + `PSTL_TICK_US - 1) / `PSTL_TICK_US)
`define PSTL_GTB_DO_TICKS \
  ((`PSTL_GTB_DO_US + `PSTL_TICK_US - 1) / `PSTL_TICK_US)
// trip delay and reversal guard, in ticks
`define PSTL_TD_PU_TICKS   4
`define PSTL_RG_PU_TICKS   2
`define PSTL_RG_DO_TICKS   3
`endif

// ===== verilog/pstl_pkg.sv
// Purpose: types for the pilot scheme trip logic
// Assumes: nothing beyond the consts header
// Notes:   element flags travel as one packed struct
package pstl_pkg;
  // =====================================================================
  // element flags from the measuring functions
  typedef struct packed {
    logic zone1;        // underreaching zone 1 operated
    logic overreach;    // any overreaching trip function operated
    logic dist_block;   // phase/ground distance blocking function
    logic ground_directional_overcurrent_block;   // ground directional overcurrent block
    logic gnd_blk_oc;   // ground block overcurrent, restrained
    logic gnd_blk_unr;  // ground block overcurrent, unrestrained
    logic neg_seq_blk;  // negative sequence block
    logic fault_det;    // fault detector
    logic oos_block;    // out-of-step blocking
  } pstl_elem_t;
  // scheme modes
  typedef enum logic [2:0] {
    PSTL_POTT = 3'h1,
    PSTL_PUTT = 3'h2,
    PSTL_BLOCKING_VARIANT_ONE = 3'h4,
    PSTL_BLOCKING_VARIANT_TWO = 3'h5,
    PSTL_BLOCKING_VARIANT_THREE = 3'h6
  } pstl_mode_t;
  typedef enum logic [1:0] {PSTL_TIDLE, PSTL_TPU, PSTL_THELD, PSTL_TDO} pstl_tstate_t;
endpackage : pstl_pkg

// ===== verilog/pstl_trip.sv
// Purpose: pilot scheme trip and transmitter keying logic
// Assumes: inputs synchronous to i_ref_clk, timers count processing ticks
// Notes:   backup stepped zones live outside this block
// Functional notes
// - overreach trips via comparator and keys transmitter
// - overreach comparator needs receiver one, no out-of-step
// - pickup timer delays comparator before trip
// - reversal guard timer works with trip delay
// - fault detector gates every trip
// - three-terminal overreach needs both receivers
// - breaker open keys transmitter; two breakers ANDed
// - underreach zone 1 trips directly, keys transmitter
// - underreach others need overreach plus receiver
// - three-terminal underreach ORs both receivers
// - breaker keying suppressed for underreach, two receivers
// - blocking: overreach inhibits blocking, stops carrier
// - blocking trip after coordination timer, no out-of-step
// - blocking: received signal removes trip permission
// - local block keys transmitter, blocks local trip
// - ground carrier start chosen by variant
// - ground block held 25 ms gets 30 ms dropout
// - distance block has same transient block timer
// - tripping functions override and reset distance blocking
// - three-terminal tones: receiver two joins receiver one
// - transmitter stop input turns transmitter off
// - pilot disable input disables all pilot logic
`timescale 1ns/1ns
`include "pstl_consts.svh"
module pstl_trip #(
  parameter int TICK_CYC   = `PSTL_TICK_CYC,     // clock cycles per tick
  parameter int TD_PU      = `PSTL_TD_PU_TICKS,  // trip delay pickup, ticks
  parameter int RG_PU      = `PSTL_RG_PU_TICKS,  // reversal guard pickup
  parameter int RG_DO      = `PSTL_RG_DO_TICKS,  // reversal guard dropout
  parameter int GTB_PU     = `PSTL_GTB_PU_TICKS, // ground block pickup
  parameter int GTB_DO     = `PSTL_GTB_DO_TICKS, // ground block dropout
  parameter int DTB_PU     = `PSTL_GTB_PU_TICKS, // distance block pickup
  parameter int DTB_DO     = `PSTL_GTB_DO_TICKS  // distance block dropout
) (
  // clock and reset
  input  wire logic           i_ref_clk,
  input  wire logic           i_rst,
  // settings
  input  wire pstl_pkg::pstl_mode_t i_scheme_select,
  input  wire logic           i_receiver_count_two,
  input  wire logic           i_two_breakers,
  // element flags
  input  wire pstl_pkg::pstl_elem_t i_elem,
  // contact converter inputs
  input  wire logic           i_breaker_open_input_a,
  input  wire logic           i_breaker_open_input_b,
  input  wire logic           i_receiver_input_one,
  input  wire logic           i_receiver_input_two,
  input  wire logic           i_transmitter_stop_input,
  input  wire logic           i_pilot_disable_input,
  // outputs
  output logic                o_pilot_trip,
  output logic                o_tx_key,
  output logic                o_carrier_start,
  output logic                o_carrier_stop,
  output logic                o_tick
);
  import pstl_pkg::*;
  // every assertion below runs on the reference clock
  default clocking cb_ref @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // refuse settings the 24-bit tick and 8-bit timer counters cannot hold
  if (TICK_CYC < 1 || TICK_CYC > 16777216 || TD_PU < 1 ||
      GTB_PU < 1 || GTB_DO < 1 || DTB_PU < 1 || DTB_DO < 1 ||
      RG_PU < 0 || RG_DO < 0 || TD_PU > 255 || RG_PU > 255 ||
      RG_DO > 255 || GTB_PU > 255 || GTB_DO > 255 ||
      DTB_PU > 255 || DTB_DO > 255) begin : g_bad_timer
    $error("pstl_trip: timer setting out of range");
  end

  // =====================================================================
  // processing tick
  logic [23:0] tick_cnt_r;                 // cycles within one tick
  logic        tick_r;                     // one-cycle tick pulse

  // common tick for every scheme timer
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tick_cnt_r <= 24'h0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 24'(TICK_CYC - 1)) begin
      tick_cnt_r <= 24'h0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 24'h1;
      tick_r     <= 1'b0;
    end
  end

  // =====================================================================
  // mode decode
  logic pilot_on;                          // pilot logic enabled
  logic m_pott, m_putt, m_blk;             // scheme families
  assign pilot_on = !i_pilot_disable_input;
  assign m_pott   = pilot_on && (i_scheme_select == PSTL_POTT);
  assign m_putt   = pilot_on && (i_scheme_select == PSTL_PUTT);
  assign m_blk    = pilot_on && (i_scheme_select == PSTL_BLOCKING_VARIANT_ONE ||
                                 i_scheme_select == PSTL_BLOCKING_VARIANT_TWO ||
                                 i_scheme_select == PSTL_BLOCKING_VARIANT_THREE);

  // =====================================================================
  // receiver combination
  logic rx_perm;                           // permissive receiver term
  logic rx_block;                          // received blocking signal
  always_comb begin
    if (!i_receiver_count_two)
      rx_perm = i_receiver_input_one;
    else if (m_putt)                       // one end may see zone 1
      rx_perm = i_receiver_input_one || i_receiver_input_two;
    else
      rx_perm = i_receiver_input_one && i_receiver_input_two;
  end
  assign rx_block = i_receiver_input_one ||
                    (i_receiver_count_two && i_receiver_input_two);

  // =====================================================================
  // pickup/dropout timers: one shared counter form
  logic [7:0] rg_pu_r, rg_do_r;            // reversal guard counts
  logic       rg_out_r;                    // reversal guard output
  logic [7:0] td_cnt_r;                    // trip delay count
  logic       td_out_r;                    // trip delay output
  logic       perm_cmp, blk_cmp, cmp_in;   // comparator outputs

  // reversal guard on the overreach path: pickup then dropout
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rg_pu_r  <= 8'h0;
      rg_do_r  <= 8'h0;
      rg_out_r <= 1'b0;
    end else if (tick_r) begin
      if (i_elem.overreach) begin
        rg_do_r <= 8'h0;
        if (rg_pu_r >= 8'(RG_PU)) rg_out_r <= 1'b1;
        else rg_pu_r <= rg_pu_r + 8'h1;
      end else begin
        rg_pu_r <= 8'h0;
        if (rg_do_r >= 8'(RG_DO)) rg_out_r <= 1'b0;
        else rg_do_r <= rg_do_r + 8'h1;
      end
    end
  end

  // permissive comparator: overreach, receiver, no out-of-step
  assign perm_cmp = (m_pott || m_putt) && i_elem.overreach && rg_out_r &&
                    rx_perm && !i_elem.oos_block;

  // =====================================================================
  // blocking side: transient block timers
  logic [7:0] gtb_pu_r, gtb_do_r;          // ground block timer counts
  logic       gtb_held_r;                  // ground block extended
  logic [7:0] dtb_pu_r, dtb_do_r;          // distance block counts
  logic       dtb_held_r;                  // distance block extended
  logic       dist_blk_eff;                // inhibited distance block
  logic       gnd_start;                   // ground carrier start
  logic       local_block;                 // any local block function

  // tripping functions inhibit the distance blocking functions
  assign dist_blk_eff = i_elem.dist_block && !i_elem.overreach;

  // ground start chosen by variant
  always_comb begin
    case (i_scheme_select)
      PSTL_BLOCKING_VARIANT_ONE: gnd_start = i_elem.gnd_blk_oc && i_elem.neg_seq_blk;
      PSTL_BLOCKING_VARIANT_TWO: gnd_start = i_elem.fault_det;
      PSTL_BLOCKING_VARIANT_THREE: gnd_start = i_elem.gnd_blk_unr;
      default:   gnd_start = 1'b0;
    endcase
  end

  // ground block: whole ticks counted, so neither span falls short
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      gtb_pu_r   <= 8'h0;
      gtb_do_r   <= 8'h0;
      gtb_held_r <= 1'b0;
    end else if (tick_r) begin
      if (i_elem.ground_directional_overcurrent_block) begin
        gtb_do_r <= 8'h0;
        if (gtb_pu_r >= 8'(GTB_PU)) gtb_held_r <= 1'b1;
        else gtb_pu_r <= gtb_pu_r + 8'h1;
      end else begin
        gtb_pu_r <= 8'h0;
        if (gtb_do_r >= 8'(GTB_DO)) gtb_held_r <= 1'b0;
        else if (gtb_held_r) gtb_do_r <= gtb_do_r + 8'h1;
      end
    end
  end

  // distance block: same shape, reset by tripping functions
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || i_elem.overreach) begin
      dtb_pu_r   <= 8'h0;
      dtb_do_r   <= 8'h0;
      dtb_held_r <= 1'b0;
    end else if (tick_r) begin
      if (dist_blk_eff) begin
        dtb_do_r <= 8'h0;
        if (dtb_pu_r >= 8'(DTB_PU)) dtb_held_r <= 1'b1;
        else dtb_pu_r <= dtb_pu_r + 8'h1;
      end else begin
        dtb_pu_r <= 8'h0;
        if (dtb_do_r >= 8'(DTB_DO)) dtb_held_r <= 1'b0;
        else if (dtb_held_r) dtb_do_r <= dtb_do_r + 8'h1;
      end
    end
  end

  assign local_block = dist_blk_eff || dtb_held_r ||
                       i_elem.ground_directional_overcurrent_block || gtb_held_r;

  // blocking comparator: no received block, no local block
  assign blk_cmp = m_blk && i_elem.overreach && !rx_block &&
                   !local_block && !i_elem.oos_block;

  assign cmp_in = perm_cmp || blk_cmp;

  // =====================================================================
  // trip delay timer: pickup on the comparator output
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !cmp_in) begin
      td_cnt_r <= 8'h0;
      td_out_r <= 1'b0;
    end else if (tick_r) begin
      if (td_cnt_r >= 8'(TD_PU - 1)) td_out_r <= 1'b1;
      else td_cnt_r <= td_cnt_r + 8'h1;
    end
  end

  // =====================================================================
  // outputs
  logic trip_nxt, key_nxt, start_nxt, stop_nxt;
  logic brk_open;                          // line open indication

  assign brk_open = i_two_breakers ?
                    (i_breaker_open_input_a && i_breaker_open_input_b) :
                    i_breaker_open_input_a;

  // combine trip and channel keying
  always_comb begin
    trip_nxt  = ((td_out_r && cmp_in) || (m_putt && i_elem.zone1)) &&
                i_elem.fault_det;
    key_nxt   = 1'b0;
    start_nxt = 1'b0;
    stop_nxt  = 1'b0;
    if (m_pott || m_putt) begin
      key_nxt = i_elem.overreach || (m_putt && i_elem.zone1) ||
                (brk_open && !(m_putt && i_receiver_count_two));
    end else if (m_blk) begin
      start_nxt = (local_block || gnd_start) && !i_elem.overreach;
      stop_nxt  = i_elem.overreach;
      key_nxt   = start_nxt;
    end
    if (i_transmitter_stop_input) begin
      key_nxt   = 1'b0;
      start_nxt = 1'b0;
      stop_nxt  = m_blk;
    end
  end

  // registered outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pilot_trip    <= 1'b0;
      o_tx_key        <= 1'b0;
      o_carrier_start <= 1'b0;
      o_carrier_stop  <= 1'b0;
    end else begin
      o_pilot_trip    <= trip_nxt;
      o_tx_key        <= key_nxt;
      o_carrier_start <= start_nxt;
      o_carrier_stop  <= stop_nxt;
    end
  end
  assign o_tick = tick_r;

  // =====================================================================
  // assertions: all on i_ref_clk, quiet while reset is held
  // trip chain first step: timer run out, comparator still made
  sequence s_td_made;
    td_out_r && cmp_in && i_elem.fault_det;
  endsequence
  // trip chain second step: the registered trip output
  sequence s_trip_out;
    o_pilot_trip;
  endsequence

  a_trip_needs_fd: assert property (
    o_pilot_trip |-> $past(i_elem.fault_det))
    else $error("trip without fault detector");
  a_disable_quiet: assert property (
    $past(i_pilot_disable_input) |->
      !o_pilot_trip && !o_tx_key && !o_carrier_start && !o_carrier_stop)
    else $error("pilot active while disabled");
  a_stop_kills_tx: assert property (
    $past(i_transmitter_stop_input) |-> !o_tx_key && !o_carrier_start)
    else $error("transmitter on during stop");
  a_putt_z1_trip: assert property (
    (m_putt && i_elem.zone1 && i_elem.fault_det && !i_transmitter_stop_input)
      |=> o_pilot_trip && o_tx_key)
    else $error("zone 1 direct trip missing");
  a_pott_key: assert property (
    (m_pott && i_elem.overreach && !i_transmitter_stop_input) |=> o_tx_key)
    else $error("overreach did not key");
  a_putt_brk_sup: assert property (
    (m_putt && i_receiver_count_two && !i_elem.zone1 && !i_elem.overreach)
      |=> !o_tx_key)
    else $error("breaker keying not suppressed");
  a_blk_stop: assert property (
    (m_blk && i_elem.overreach) |=> !o_carrier_start && o_carrier_stop)
    else $error("carrier kept during overreach");
  a_blk_rx_block: assert property (
    (m_blk && rx_block) |=> !td_out_r && !o_pilot_trip)
    else $error("trip path ran with block received");
  a_gtb_hold: assert property (
    (gtb_held_r && $fell(i_elem.ground_directional_overcurrent_block)) |=> gtb_held_r [*8])
    else $error("ground block dropout not extended");
  a_gtb_span: assert property (
    ($fell(gtb_held_r) && !$past(i_rst)) |-> $past(gtb_do_r) == 8'(GTB_DO))
    else $error("ground block dropped before its full dropout");
  a_td_trip: assert property (
    s_td_made |=> s_trip_out)
    else $error("expired trip delay gave no trip");
  a_trip_source: assert property (
    $rose(o_pilot_trip) |-> $past(td_out_r) || $past(m_putt && i_elem.zone1))
    else $error("trip without timer or zone 1");
  a_perm_needs_rx: assert property (
    (m_pott && !rx_perm) |=> !o_pilot_trip)
    else $error("overreach trip without receiver permission");
  a_oos_no_trip: assert property (
    (i_elem.oos_block && !(m_putt && i_elem.zone1)) |=> !o_pilot_trip)
    else $error("trip during out-of-step block");
  a_local_blk_trip: assert property (
    (m_blk && local_block) |=> !o_pilot_trip)
    else $error("trip while local block stands");
  a_brk_key: assert property (
    (m_pott && brk_open && !i_transmitter_stop_input) |=> o_tx_key)
    else $error("open breaker did not key");
  a_dtb_reset: assert property (
    i_elem.overreach |=> !dtb_held_r)
    else $error("distance block held through a trip");
  a_blocking_variant_two_start: assert property (
    (i_scheme_select == PSTL_BLOCKING_VARIANT_TWO && pilot_on && i_elem.fault_det &&
     !i_elem.overreach && !i_transmitter_stop_input) |=> o_carrier_start)
    else $error("fault detector did not start carrier");
endmodule : pstl_trip
